/* hw/cpr_ctrl.sv */
// Purpose: power-down modes, offset autocalibration and sample-rate control
// Assumes: inputs synchronous to i_clk; registers over a plain strobe port
// Notes: reads return the busy value while initialising or resynchronising
//
// Summary of operation
// - total power-down bit set only in mode change, clearing always taken
// - clearing total bit runs 512 ms initialisation
// - total power-down: all off, FIFOs flushed
// - 3 ms total entry, one sample partials
// - exit in one sample, 128 more to unmute
// - standby mutes, keeps reference, flushes both
// - mixer power-down: playback off, capture alive
// - mixer-only: both converters off, flush both
// - ADC power-down flushes capture, playback continues
// - DAC power-down flushes playback, capture continues
// - first mode change exit always calibrates
// - later exits calibrate only on request
// - calibration flag high 384 sample periods
// - transfers held off during calibration
// - calibration invalidates converter data paths
// - rate from divide table or frequency registers
// - resync ignores writes, reads return 80h
// - on-the-fly busy 200 us unless skipped
// - expanded mode rate in 1 Hz steps
// - hardware power-down pin overrides software states
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module cpr_ctrl #(
    parameter int INIT_CYCLES = cpr_pkg::INIT_CYC,
    parameter int TPD_CYCLES = cpr_pkg::TPD_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hw_pd_n, // hardware power-down pin, low = down
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output cpr_pkg::cpr_pwr_s o_pwr, // converter, mixer, reference controls
    output logic o_xfer_hold, // capture and playback transfers held off
    output logic o_cal_run, // converter data meaningless, dac input ignored
    output logic o_sample_tick, // one pulse per sample period
    output logic [15:0] o_rate_hz // active sample rate
);
    // ==========================================================
    // state
    typedef enum logic [2:0] {
        ST_INIT, ST_RUN, ST_TPD_DN, ST_TPD, ST_HWPD, ST_BUSY, ST_CAL
    } cpr_st_e;

    cpr_st_e st_q; // main sequencer state
    logic [23:0] cnt_q; // cycle counter, counts up
    logic [8:0] tk_q; // sample-tick counter for calibration, counts up
    logic [7:0] ctrl_q; // mode change, autocal request, skip, mode, freq_register_enable
    logic [7:0] pwr_q; // partial power-down bits
    logic [7:0] tot_q; // total power-down bit
    logic [7:0] clk_q; // clock divide and source
    logic [7:0] fu_q; // frequency select upper byte
    logic [7:0] fl_q; // frequency select lower byte
    logic cal_done_q; // a calibration has run since init
    logic [24:0] acc_q; // sample rate phase accumulator
    cpr_pkg::cpr_pmode_e mode_q; // applied power mode
    logic [7:0] unm_q; // remaining unmute sample periods
    logic [15:0] rate; // selected sample rate
    logic busy; // reads show busy value
    logic wr_ok; // write is accepted
    logic mce_fall; // write leaves the mode change state
    logic clk_wr; // write to clock and format register
    logic [24:0] acc_sum; // accumulator next sum
    cpr_pkg::cpr_pmode_e req_mode; // decoded requested mode
    cpr_pkg::cpr_pwr_s pwr_d; // power controls of the applied mode

    // ==========================================================
    // functions
    // fixed-priority mode decode, unlisted combinations go to superset
    function automatic cpr_pkg::cpr_pmode_e decode(input logic t, input logic a,
                                                   input logic d, input logic m);
        if (t) begin
            decode = cpr_pkg::PM_TOTAL;
        end else if (a && m) begin
            decode = cpr_pkg::PM_STANDBY;
        end else if (m) begin
            decode = cpr_pkg::PM_MIXPD;
        end else if (a && d) begin
            decode = cpr_pkg::PM_MIXONLY;
        end else if (a) begin
            decode = cpr_pkg::PM_ADCPD;
        end else if (d) begin
            decode = cpr_pkg::PM_DACPD;
        end else begin
            decode = cpr_pkg::PM_OPER;
        end
    endfunction

    // compat divide table, source select halves the rate
    function automatic logic [15:0] table_rate(input logic [2:0] cds, input logic clock_source_select);
        logic [15:0] r;
        r = 16'h1f40;
        unique case (cds)
            3'h0: r = 16'h1f40; // 8000
            3'h1: r = 16'h2b11; // 11025
            3'h2: r = 16'h3e80; // 16000
            3'h3: r = 16'h5622; // 22050
            3'h4: r = 16'h7d00; // 32000
            3'h5: r = 16'h93a8; // 37800
            3'h6: r = 16'hac44; // 44100
            3'h7: r = 16'hbb80; // 48000
        endcase
        table_rate = clock_source_select ? (r >> 1) : r;
    endfunction

    // ==========================================================
    // decode of bus requests
    always_comb begin
        busy = (st_q == ST_INIT) || (st_q == ST_BUSY) || (st_q == ST_HWPD);
        wr_ok = i_wr && !busy;
        clk_wr = wr_ok && (i_addr == cpr_pkg::A_CLK);
        mce_fall = wr_ok && (i_addr == cpr_pkg::A_CTRL) && ctrl_q[cpr_pkg::B_MCE]
                   && !i_wdata[cpr_pkg::B_MCE];
        req_mode = decode(tot_q[cpr_pkg::B_TOT], pwr_q[cpr_pkg::B_ADC],
                          pwr_q[cpr_pkg::B_DAC], pwr_q[cpr_pkg::B_MIX]);
        // frequency registers take over in expanded mode with freq_register_enable set
        if (ctrl_q[cpr_pkg::B_EXP] && ctrl_q[cpr_pkg::B_FREQ_REGISTER_ENABLE]) begin
            rate = {fu_q, fl_q};
        end else begin
            rate = table_rate(clk_q[2:0], clk_q[cpr_pkg::B_CSS]);
        end
    end

    // ==========================================================
    // register file
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= cpr_pkg::CTRL_RST;
            pwr_q <= cpr_pkg::PWR_RST;
            tot_q <= 8'h00;
            clk_q <= cpr_pkg::CLK_RST;
            fu_q <= cpr_pkg::FU_RST;
            fl_q <= cpr_pkg::FL_RST;
        end else if (st_q == ST_INIT || st_q == ST_HWPD) begin
            // defaults restored by initialisation
            ctrl_q <= cpr_pkg::CTRL_RST;
            pwr_q <= cpr_pkg::PWR_RST;
            tot_q <= 8'h00;
            clk_q <= cpr_pkg::CLK_RST;
            fu_q <= cpr_pkg::FU_RST;
            fl_q <= cpr_pkg::FL_RST;
        end else if (wr_ok) begin
            unique case (i_addr)
                cpr_pkg::A_CTRL: ctrl_q <= {3'h0, i_wdata[4:0]};
                cpr_pkg::A_PWR: pwr_q <= {5'h0, i_wdata[2:0]};
                cpr_pkg::A_TOT: begin
                    // setting needs mode change, clearing is always taken
                    if (ctrl_q[cpr_pkg::B_MCE] || !i_wdata[cpr_pkg::B_TOT]) begin
                        tot_q <= {7'h0, i_wdata[cpr_pkg::B_TOT]};
                    end
                end
                cpr_pkg::A_CLK: clk_q <= {4'h0, i_wdata[3:0]};
                cpr_pkg::A_FU: fu_q <= i_wdata;
                cpr_pkg::A_FL: fl_q <= i_wdata;
                default: begin
                    // status and unmapped: write ignored
                end
            endcase
        end
    end

    // ==========================================================
    // main sequencer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= ST_INIT;
            cnt_q <= 24'h0;
            tk_q <= 9'h0;
            cal_done_q <= 1'b0;
        end else if (!i_hw_pd_n) begin
            st_q <= ST_HWPD;
            cal_done_q <= 1'b0;
        end else begin
            unique case (st_q)
                ST_HWPD: begin
                    st_q <= ST_INIT;
                    cnt_q <= 24'h0;
                end
                ST_INIT: begin
                    // full initialisation delay
                    if (cnt_q == 24'(INIT_CYCLES - 1)) begin
                        st_q <= ST_RUN;
                        cnt_q <= 24'h0;
                    end else begin
                        cnt_q <= cnt_q + 24'h1;
                    end
                end
                ST_RUN: begin
                    if (tot_q[cpr_pkg::B_TOT]) begin
                        st_q <= ST_TPD_DN;
                        cnt_q <= 24'h0;
                    end else if (mce_fall && (!cal_done_q || ctrl_q[cpr_pkg::B_AUTOCAL_REQUEST])) begin
                        st_q <= ST_CAL;
                        tk_q <= 9'h0;
                        cal_done_q <= 1'b1;
                    end else if (clk_wr && (ctrl_q[cpr_pkg::B_MCE]
                                 || !ctrl_q[cpr_pkg::B_SKIP])) begin
                        st_q <= ST_BUSY;
                        cnt_q <= 24'h0;
                    end
                end
                ST_BUSY: begin
                    // resynchronisation to the new clock
                    if (cnt_q == 24'(cpr_pkg::FAST_CYC - 1)) begin
                        st_q <= ST_RUN;
                        cnt_q <= 24'h0;
                    end else begin
                        cnt_q <= cnt_q + 24'h1;
                    end
                end
                ST_CAL: begin
                    // count sample periods of calibration
                    if (o_sample_tick) begin
                        if (tk_q == 9'(cpr_pkg::CAL_TICKS - 1)) begin
                            st_q <= ST_RUN;
                        end else begin
                            tk_q <= tk_q + 9'h1;
                        end
                    end
                end
                ST_TPD_DN: begin
                    // sequenced shutdown before total power-down
                    if (cnt_q == 24'(TPD_CYCLES - 1)) begin
                        st_q <= ST_TPD;
                        cnt_q <= 24'h0;
                    end else begin
                        cnt_q <= cnt_q + 24'h1;
                    end
                end
                ST_TPD: begin
                    if (!tot_q[cpr_pkg::B_TOT]) begin
                        st_q <= ST_INIT;
                        cnt_q <= 24'h0;
                        cal_done_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // sample tick from rate accumulator
    assign acc_sum = acc_q + {9'h0, rate};

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            acc_q <= 25'h0;
            o_sample_tick <= 1'b0;
            o_rate_hz <= 16'h0;
        end else begin
            o_rate_hz <= rate;
            // one tick each time the sum wraps the clock rate
            if (acc_sum >= 25'(cpr_pkg::CLK_HZ)) begin
                acc_q <= acc_sum - 25'(cpr_pkg::CLK_HZ);
                o_sample_tick <= 1'b1;
            end else begin
                acc_q <= acc_sum;
                o_sample_tick <= 1'b0;
            end
        end
    end

    // ==========================================================
    // applied mode follows request one sample later
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_q <= cpr_pkg::PM_TOTAL;
            unm_q <= 8'h0;
        end else if (st_q == ST_HWPD || st_q == ST_INIT || st_q == ST_TPD) begin
            mode_q <= cpr_pkg::PM_TOTAL;
            unm_q <= 8'(cpr_pkg::UNMUTE_TICKS);
        end else if (o_sample_tick) begin
            if (req_mode != mode_q && req_mode != cpr_pkg::PM_TOTAL) begin
                mode_q <= req_mode;
                unm_q <= 8'(cpr_pkg::UNMUTE_TICKS);
            end else if (unm_q != 8'h0) begin
                unm_q <= unm_q - 8'h1;
            end
        end
    end

    // power controls of each applied mode
    always_comb begin
        pwr_d = '0;
        unique case (mode_q)
            cpr_pkg::PM_OPER: pwr_d = 7'b1111_000;
            cpr_pkg::PM_STANDBY: pwr_d = 7'b0001_111;
            cpr_pkg::PM_MIXPD: pwr_d = 7'b1001_011;
            cpr_pkg::PM_MIXONLY: pwr_d = 7'b0011_110;
            cpr_pkg::PM_ADCPD: pwr_d = 7'b0111_100;
            cpr_pkg::PM_DACPD: pwr_d = 7'b1011_010;
            cpr_pkg::PM_TOTAL: pwr_d = 7'b0000_111;
        endcase
        // restore period and calibration keep outputs muted
        if (unm_q != 8'h0 || st_q == ST_CAL || st_q == ST_TPD_DN) begin
            pwr_d.mute = 1'b1;
        end
    end

    // ==========================================================
    // output flops
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pwr <= 7'b0000_111;
            o_xfer_hold <= 1'b1;
            o_cal_run <= 1'b0;
        end else begin
            o_pwr <= pwr_d;
            o_xfer_hold <= busy || (st_q == ST_CAL);
            o_cal_run <= (st_q == ST_CAL);
        end
    end

    // read port, data valid only in the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h0;
        end else if (!i_rd) begin
            o_rdata <= 8'h0;
        end else if (busy) begin
            o_rdata <= cpr_pkg::BUSY_VAL;
        end else begin
            unique case (i_addr)
                cpr_pkg::A_CTRL: o_rdata <= ctrl_q;
                cpr_pkg::A_PWR: o_rdata <= pwr_q;
                cpr_pkg::A_TOT: o_rdata <= tot_q;
                cpr_pkg::A_CLK: o_rdata <= clk_q;
                cpr_pkg::A_FU: o_rdata <= fu_q;
                cpr_pkg::A_FL: o_rdata <= fl_q;
                cpr_pkg::A_STAT: o_rdata <= {5'h0, unm_q != 8'h0,
                                             st_q == ST_TPD, st_q == ST_CAL};
                default: o_rdata <= 8'h0;
            endcase
        end
    end
endmodule

/* hw/cpr_pkg.sv */
// Purpose: shared constants and types for codec power, calibration and rate control
// Assumes: 20 MHz system clock, 8-bit register port
// Notes: register offsets and field positions live here only
package cpr_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_HZ = 20_000_000;
    localparam int INIT_MS = 512; // full initialisation time
    localparam int TPD_MS = 3; // total power-down sequencing time
    localparam int FAST_US = 200; // on-the-fly rate change busy time
    localparam int INIT_CYC = CLK_HZ / 1000 * INIT_MS;
    localparam int TPD_CYC = CLK_HZ / 1000 * TPD_MS;
    localparam int FAST_CYC = CLK_HZ / 1_000_000 * FAST_US;
    localparam int UNMUTE_TICKS = 128; // sample periods to restore after exit
    localparam int CAL_TICKS = 384; // sample periods of autocalibration
    // ==========================================================
    // register offsets
    localparam logic [2:0] A_CTRL = 3'h0;
    localparam logic [2:0] A_PWR = 3'h1;
    localparam logic [2:0] A_TOT = 3'h2;
    localparam logic [2:0] A_CLK = 3'h3;
    localparam logic [2:0] A_FU = 3'h4;
    localparam logic [2:0] A_FL = 3'h5;
    localparam logic [2:0] A_STAT = 3'h6;
    // ==========================================================
    // field positions
    localparam int B_MCE = 0; // mode_change_state
    localparam int B_AUTOCAL_REQUEST = 1; // autocal_request
    localparam int B_SKIP = 2; // skip_init_wait
    localparam int B_EXP = 3; // expanded_mode (clear = compat_mode)
    localparam int B_FREQ_REGISTER_ENABLE = 4; // freq_register_enable
    localparam int B_ADC = 0;
    localparam int B_DAC = 1;
    localparam int B_MIX = 2;
    localparam int B_TOT = 0;
    localparam int B_CSS = 3; // clock_source_select, cds in bits 2:0
    // ==========================================================
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h01; // mode-change state after init
    localparam logic [7:0] PWR_RST = 8'h00;
    localparam logic [7:0] CLK_RST = 8'h07;
    localparam logic [7:0] FU_RST = 8'hbb;
    localparam logic [7:0] FL_RST = 8'h80;
    localparam logic [7:0] BUSY_VAL = 8'h80;
    // ==========================================================
    // types
    typedef enum logic [2:0] {
        PM_OPER, PM_STANDBY, PM_MIXPD, PM_MIXONLY, PM_ADCPD, PM_DACPD, PM_TOTAL
    } cpr_pmode_e;
    typedef struct packed {
        logic adc_on;
        logic dac_on;
        logic mix_on;
        logic vref_on;
        logic cap_flush;
        logic play_flush;
        logic mute;
    } cpr_pwr_s;
endpackage

/* testbench/cpr_ctrl_assertions.sv */
// Purpose: port-level assertions for the power, calibration and rate block
// Assumes: one clock domain, asynchronous active-high reset
// Notes: bound into every cpr_ctrl below the module
`timescale 1ns/1ps
module cpr_ctrl_chk #(
    parameter int INIT_CYCLES = 50
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hw_pd_n,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire cpr_pkg::cpr_pwr_s o_pwr,
    input wire logic o_xfer_hold,
    input wire logic o_cal_run,
    input wire logic o_sample_tick
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ====================
    // helper counters
    logic [9:0] tk_q; // sample ticks seen inside one calibration run
    int up_q; // cycles since reset release, saturating
    // tick count restarts whenever calibration is idle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tk_q <= 10'h000;
            up_q <= 0;
        end else begin
            tk_q <= !o_cal_run ? 10'h000 : tk_q + 10'(o_sample_tick);
            if (up_q < INIT_CYCLES) up_q <= up_q + 1;
        end
    end
    // ====================
    // read port, initialisation and pin power-down
    property p_rd_idle;
        !i_rd |=> o_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
    property p_init_rd;
        i_rd && up_q + 2 < INIT_CYCLES |=> o_rdata == 8'h80;
    endproperty
    a_init_rd: assert property (p_init_rd) else $error("no busy value during init");
    property p_hwpd;
        // pin to state, state to applied mode, mode to output flop: three edges of latency
        !i_hw_pd_n [*4] |-> o_pwr == 7'h07 && o_xfer_hold;
    endproperty
    a_hwpd: assert property (p_hwpd) else $error("pin power-down not obeyed");
    // ====================
    // calibration and sample timing
    property p_cal_hold;
        $rose(o_cal_run) |-> o_xfer_hold;
    endproperty
    a_cal_hold: assert property (p_cal_hold) else $error("transfers run in calibration");
    property p_cal_len;
        $fell(o_cal_run) && i_hw_pd_n |-> tk_q == 10'h180;
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
    property p_tick;
        o_sample_tick |=> !o_sample_tick [*8];
    endproperty
    a_tick: assert property (p_tick) else $error("sample tick too dense");
    // ====================
    // power output combinations
    property p_vref;
        !o_pwr.vref_on |-> o_pwr == 7'h07;
    endproperty
    a_vref: assert property (p_vref) else $error("reference off but not all off");
    property p_stby;
        !o_pwr.adc_on && !o_pwr.mix_on |-> o_pwr.cap_flush && o_pwr.play_flush && o_pwr.mute;
    endproperty
    a_stby: assert property (p_stby) else $error("standby not flushed and muted");
    property p_mixpd;
        o_pwr.adc_on && !o_pwr.mix_on |-> !o_pwr.dac_on && !o_pwr.cap_flush && o_pwr.mute;
    endproperty
    a_mixpd: assert property (p_mixpd) else $error("mixer power-down wrong");
    c_cal: cover property ($fell(o_cal_run));
    c_hwpd: cover property (!i_hw_pd_n [*2]);
    c_tot: cover property ($fell(o_pwr.vref_on) && i_hw_pd_n);
endmodule
bind cpr_ctrl cpr_ctrl_chk #(.INIT_CYCLES(INIT_CYCLES)) i_cpr_ctrl_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_hw_pd_n(i_hw_pd_n), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_pwr(o_pwr), .o_xfer_hold(o_xfer_hold), .o_cal_run(o_cal_run),
    .o_sample_tick(o_sample_tick)
);

/* testbench/cpr_ctrl_tb_top.sv */
// Purpose: self-checking bench for the power, calibration and rate block
// Assumes: 20 MHz clock, shortened init and power-down counts
// Notes: one task per scenario, each judges its own results
`timescale 1ns/1ps
module cpr_ctrl_tb_top;
    localparam int INIT_C = 50; // shortened initialisation
    localparam int TPD_C = 20; // shortened total power-down entry
    logic clk, rst, hw_pd_n, wr, rd, hold, cal, tick;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    logic [15:0] rate, d; // d holds the last byte read
    cpr_pkg::cpr_pwr_s pwr;
    int failures, n_tests, cyc_n, t0;
    cpr_ctrl #(.INIT_CYCLES(INIT_C), .TPD_CYCLES(TPD_C)) i_cpr_ctrl (
        .i_clk(clk), .i_rst(rst), .i_hw_pd_n(hw_pd_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_pwr(pwr), .o_xfer_hold(hold),
        .o_cal_run(cal), .o_sample_tick(tick), .o_rate_hz(rate)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc_n <= cyc_n + 1;
    // ====================
    // shared helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = {8'h00, rdata};
    endtask
    // poll until the busy value goes away, bounded
    task automatic poll;
        int n;
        n = 0;
        do begin
            rd_reg(cpr_pkg::A_CTRL);
            n++;
        end while (d === 16'h0080 && n < 3000);
    endtask
    // count sample ticks while calibration (sel) or mute stays up
    task automatic ticks(input bit sel, output int n);
        int k;
        n = 0;
        k = 0;
        while ((sel ? cal : pwr.mute) === 1'b1 && k < 130000) begin
            if (tick === 1'b1) n++;
            cyc(1);
            k++;
        end
    endtask
    // ====================
    // scenarios
    task automatic t_init;
        chk(16'(pwr), 16'h0007);
        rd_reg(cpr_pkg::A_CTRL);
        chk(d, 16'h0080);
        poll;
        chk(16'((cyc_n - t0) inside {[INIT_C - 1:INIT_C + 8]}), 16'h0001);
        chk(d, 16'h0001);
        rd_reg(3'h7);
        chk(d, 16'h0000);
    endtask
    task automatic t_cal;
        int n;
        wr_reg(cpr_pkg::A_CTRL, 8'h19);
        wr_reg(cpr_pkg::A_FU, 8'hff);
        wr_reg(cpr_pkg::A_FL, 8'hfe);
        cyc(3);
        chk(rate, 16'hfffe);
        wr_reg(cpr_pkg::A_CTRL, 8'h18);
        cyc(3);
        chk1(cal, 1'b1);
        chk1(hold, 1'b1);
        rd_reg(cpr_pkg::A_STAT);
        chk(d & 16'h0001, 16'h0001);
        ticks(1'b1, n);
        chk(16'(n), 16'h0180);
        chk1(hold, 1'b0);
    endtask
    task automatic t_nocal;
        wr_reg(cpr_pkg::A_CTRL, 8'h19);
        wr_reg(cpr_pkg::A_CTRL, 8'h18);
        cyc(3);
        chk1(cal, 1'b0);
        wr_reg(cpr_pkg::A_TOT, 8'h01);
        cyc(TPD_C + 5);
        chk1(pwr.vref_on, 1'b1);
        rd_reg(cpr_pkg::A_STAT);
        chk(d & 16'h0002, 16'h0000);
    endtask
    task automatic t_rate;
        logic [15:0] tbl [9] = '{16'h1f40, 16'h2b11, 16'h3e80, 16'h5622, 16'h7d00,
            16'h93a8, 16'hac44, 16'hbb80, 16'h5dc0};
        wr_reg(cpr_pkg::A_CTRL, 8'h04);
        for (int i = 0; i < 9; i++) begin
            wr_reg(cpr_pkg::A_CLK, (i < 8) ? 8'(i) : 8'h0f);
            cyc(2);
            chk(rate, tbl[i]);
            rd_reg(cpr_pkg::A_CTRL);
            chk(d, 16'h0004);
        end
        wr_reg(cpr_pkg::A_CTRL, 8'h00);
        wr_reg(cpr_pkg::A_CLK, 8'h07);
        t0 = cyc_n;
        wr_reg(cpr_pkg::A_PWR, 8'h01);
        rd_reg(cpr_pkg::A_CTRL);
        chk(d, 16'h0080);
        poll;
        chk(16'((cyc_n - t0) inside {[cpr_pkg::FAST_CYC - 2:cpr_pkg::FAST_CYC + 8]}),
            16'h0001);
        rd_reg(cpr_pkg::A_PWR);
        chk(d, 16'h0000);
        chk(rate, 16'hbb80);
        wr_reg(cpr_pkg::A_CTRL, 8'h18);
        cyc(3);
        chk(rate, 16'hfffe);
    endtask
    task automatic t_modes;
        logic [2:0] cd [8] = '{3'h5, 3'h4, 3'h3, 3'h1, 3'h2, 3'h7, 3'h6, 3'h0};
        logic [5:0] ex [8] = '{6'h07, 6'h25, 6'h0f, 6'h1e, 6'h2d, 6'h07, 6'h25, 6'h3c};
        int n;
        for (int i = 0; i < 8; i++) begin
            wr_reg(cpr_pkg::A_PWR, {5'h00, cd[i]});
            n = 0;
            while (16'(pwr) >> 1 !== 16'(ex[i]) && n < 320) begin
                cyc(1);
                n++;
            end
            chk(16'(pwr) >> 1, 16'(ex[i]));
            if (!ex[i][3]) chk1(pwr.mute, 1'b1);
        end
        ticks(1'b0, n);
        chk(16'(n inside {[127:129]}), 16'h0001);
    endtask
    task automatic t_total;
        wr_reg(cpr_pkg::A_CTRL, 8'h19);
        wr_reg(cpr_pkg::A_TOT, 8'h01);
        cyc(3);
        chk1(pwr.mute, 1'b1);
        cyc(TPD_C - 6);
        chk1(pwr.vref_on, 1'b1);
        cyc(10);
        chk(16'(pwr), 16'h0007);
        rd_reg(cpr_pkg::A_STAT);
        chk(d & 16'h0002, 16'h0002);
        wr_reg(cpr_pkg::A_TOT, 8'h00);
        rd_reg(cpr_pkg::A_CTRL);
        chk(d, 16'h0080);
        poll;
        chk(d, 16'h0001);
        chk(rate, 16'hbb80);
    endtask
    task automatic t_hwpd;
        wr_reg(cpr_pkg::A_PWR, 8'h01);
        @(posedge clk);
        hw_pd_n <= 1'b0;
        cyc(3);
        chk(16'(pwr), 16'h0007);
        chk1(hold, 1'b1);
        rd_reg(cpr_pkg::A_CTRL);
        chk(d, 16'h0080);
        @(posedge clk);
        hw_pd_n <= 1'b1;
        poll;
        chk(d, 16'h0001);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watchdog: the run needs about 170k cycles, mostly calibration and unmute
    initial begin
        repeat (250000) @(posedge clk);
        failures++;
        print_verdict;
    end
    initial begin
        rst = 1'b1;
        hw_pd_n = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t0 = cyc_n;
        t_init;
        t_cal;
        t_nocal;
        t_rate;
        t_modes;
        t_total;
        t_hwpd;
        print_verdict;
    end
endmodule
